// ### verilog/wtc_top.sv
// Wake-up timer configuration, prescaled counter and AXI4-Lite register slave.
//
// Notes on behaviour
// - codes 4-7 divide by 128 up to 65536.
// - bit 6 powers the RC slow oscillator.
// - bit 5 powers the crystal slow oscillator.
// - bit 4 picks RC (1) or crystal (0).
// - bit 3 keeps backup RAM powered asleep.
// - bit 0 lets timeout wake the device.
`timescale 1ns/1ps
`default_nettype none

module wtc_top #(
    parameter int COUNT_WIDTH = 16
) (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        rc_slow_oscillator,
    input  wire logic        crystal_slow_oscillator,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             rc_slow_osc_enable,
    output logic             crystal_slow_osc_enable,
    output logic             slow_clock_source_select,
    output logic             backup_ram_sleep_power,
    output logic             sleep_state,
    output logic             wake,
    output logic             irq
);

    if (COUNT_WIDTH < 1 || COUNT_WIDTH > 32) begin
        $error("wtc_top: COUNT_WIDTH must lie between 1 and 32");
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]                      wakeup_timer_config_low;
    logic [2:0]                      wakeup_timer_config_high;
    logic [COUNT_WIDTH-1:0]          reload;
    logic [COUNT_WIDTH-1:0]          count;
    logic [wtc_pkg::IRQ_WIDTH-1:0]   irq_status;
    logic [wtc_pkg::IRQ_WIDTH-1:0]   irq_mask;
    logic                            run;

    logic                            timeout_wake_arm;
    logic [2:0]                      tick_prescale_select;
    assign tick_prescale_select = wakeup_timer_config_high;

    assign rc_slow_osc_enable       = wakeup_timer_config_low[wtc_pkg::BIT_RC_OSC_EN];
    assign crystal_slow_osc_enable  = wakeup_timer_config_low[wtc_pkg::BIT_XTAL_OSC_EN];
    assign slow_clock_source_select = wakeup_timer_config_low[wtc_pkg::BIT_CLK_SEL];
    assign timeout_wake_arm         = wakeup_timer_config_low[wtc_pkg::BIT_WAKE_ARM];

    assign backup_ram_sleep_power = ~sleep_state
        | wakeup_timer_config_low[wtc_pkg::BIT_BATTERY_BACKED_RAM_PWR];

    // ------------------------------------------------------------------
    // Slow clock sampling
    // ------------------------------------------------------------------
    // The slow clocks are sampled as pins; a disabled oscillator yields no edges.
    logic [2:0] rc_sync;
    logic [2:0] xtal_sync;
    logic       slow_level;
    logic       slow_prev;
    logic       slow_edge;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rc_sync   <= 3'h0;
            xtal_sync <= 3'h0;
        end else begin
            rc_sync   <= {rc_sync[1:0], rc_slow_oscillator & rc_slow_osc_enable};
            xtal_sync <= {xtal_sync[1:0], crystal_slow_oscillator & crystal_slow_osc_enable};
        end
    end

    // Source switching can give one stray edge; the tick period is coarse enough to bear it.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            slow_level <= 1'b0;
        end else if (slow_clock_source_select) begin
            if (rc_sync[1] == rc_sync[2]) begin
                slow_level <= rc_sync[2];
            end
        end else begin
            if (xtal_sync[1] == xtal_sync[2]) begin
                slow_level <= xtal_sync[2];
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            slow_prev <= 1'b0;
        end else begin
            slow_prev <= slow_level;
        end
    end

    assign slow_edge = slow_level & ~slow_prev;

    // ------------------------------------------------------------------
    // Prescaler and timeout counter
    // ------------------------------------------------------------------
    logic tick;
    logic timeout;

    wtc_prescaler #(
        .WIDTH (wtc_pkg::PRESCALE_WIDTH)
    ) u_prescaler (
        .mclk                 (mclk),
        .nrst                 (nrst),
        .slow_edge            (slow_edge),
        .run                  (run),
        .tick_prescale_select (tick_prescale_select),
        .tick                 (tick)
    );

    assign timeout = run & tick & (count == '0);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
        end else if (!run) begin
            count <= reload;
        end else if (tick) begin
            count <= (count == '0) ? reload : count - 1'b1;
        end
    end

    assign wake = timeout & timeout_wake_arm & sleep_state;

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign do_write      = aw_held & w_held & ~s_axi_bvalid;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    function automatic logic addr_known(input logic [7:0] a);
        case (a)
            wtc_pkg::ADDR_CONFIG_LOW, wtc_pkg::ADDR_CONFIG_HIGH, wtc_pkg::ADDR_RELOAD,
            wtc_pkg::ADDR_COUNT, wtc_pkg::ADDR_IRQ_STATUS, wtc_pkg::ADDR_IRQ_MASK,
            wtc_pkg::ADDR_CONTROL: addr_known = 1'b1;
            default: addr_known = 1'b0;
        endcase
    endfunction

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= wtc_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_known(aw_addr) ? wtc_pkg::RESP_OKAY : wtc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic wr_low;
    assign wr_low = do_write & w_strb[0];

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wakeup_timer_config_low <= wtc_pkg::CONFIG_LOW_RESET;
        end else if (wr_low && aw_addr == wtc_pkg::ADDR_CONFIG_LOW) begin
            wakeup_timer_config_low <= w_data[7:0] & wtc_pkg::CONFIG_LOW_WMASK;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wakeup_timer_config_high <= wtc_pkg::CONFIG_HIGH_RESET;
        end else if (wr_low && aw_addr == wtc_pkg::ADDR_CONFIG_HIGH) begin
            wakeup_timer_config_high <= w_data[2:0];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reload <= '0;
        end else if (do_write && aw_addr == wtc_pkg::ADDR_RELOAD) begin
            for (int i = 0; i < COUNT_WIDTH; i++) begin
                if (w_strb[i/8]) begin
                    reload[i] <= w_data[i];
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            run         <= 1'b0;
            sleep_state <= 1'b0;
        end else if (wr_low && aw_addr == wtc_pkg::ADDR_CONTROL) begin
            run         <= w_data[wtc_pkg::CTRL_RUN];
            sleep_state <= w_data[wtc_pkg::CTRL_SLEEP];
        end else if (wake) begin
            sleep_state <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_mask <= '0;
        end else if (wr_low && aw_addr == wtc_pkg::ADDR_IRQ_MASK) begin
            irq_mask <= w_data[wtc_pkg::IRQ_WIDTH-1:0];
        end
    end

    // An event in the clearing cycle stays set.
    logic [wtc_pkg::IRQ_WIDTH-1:0] irq_set;
    logic [wtc_pkg::IRQ_WIDTH-1:0] irq_clr;
    assign irq_set = {wake, timeout};
    assign irq_clr = (wr_low && aw_addr == wtc_pkg::ADDR_IRQ_STATUS)
        ? w_data[wtc_pkg::IRQ_WIDTH-1:0] : '0;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= wtc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= wtc_pkg::RESP_OKAY;
            case (s_axi_araddr)
                wtc_pkg::ADDR_CONFIG_LOW:  s_axi_rdata <= {24'h000000, wakeup_timer_config_low};
                wtc_pkg::ADDR_CONFIG_HIGH: s_axi_rdata <= {29'h0, wakeup_timer_config_high};
                wtc_pkg::ADDR_RELOAD:      s_axi_rdata <= 32'(reload);
                wtc_pkg::ADDR_COUNT:       s_axi_rdata <= 32'(count);
                wtc_pkg::ADDR_IRQ_STATUS:  s_axi_rdata <= 32'(irq_status);
                wtc_pkg::ADDR_IRQ_MASK:    s_axi_rdata <= 32'(irq_mask);
                wtc_pkg::ADDR_CONTROL:     s_axi_rdata <= {30'h0, sleep_state, run};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= wtc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ### verilog/wtc_pkg.sv
// Package with the register map, field positions and prescaler constants of the wake-up timer.
package wtc_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG_LOW   = 8'h00;
    localparam logic [7:0] ADDR_CONFIG_HIGH  = 8'h04;
    localparam logic [7:0] ADDR_RELOAD       = 8'h08;
    localparam logic [7:0] ADDR_COUNT        = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK     = 8'h14;
    localparam logic [7:0] ADDR_CONTROL      = 8'h18;

    // ------------------------------------------------------------------
    // Field positions of the low configuration byte
    // ------------------------------------------------------------------
    localparam int BIT_RC_OSC_EN   = 6;
    localparam int BIT_XTAL_OSC_EN = 5;
    localparam int BIT_CLK_SEL     = 4;
    localparam int BIT_BATTERY_BACKED_RAM_PWR   = 3;
    localparam int BIT_WAKE_ARM    = 0;
    localparam logic [7:0] CONFIG_LOW_WMASK  = 8'h79;
    localparam logic [7:0] CONFIG_LOW_RESET  = 8'h00;
    localparam logic [2:0] CONFIG_HIGH_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Interrupt status bits and control bits
    // ------------------------------------------------------------------
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_WAKE    = 1;
    localparam int IRQ_WIDTH   = 2;
    localparam int CTRL_RUN    = 0;
    localparam int CTRL_SLEEP  = 1;

    // ------------------------------------------------------------------
    // Prescaler shift amounts: the divider is two to this power
    // ------------------------------------------------------------------
    localparam int PRESCALE_WIDTH = 16;
    localparam logic [4:0] SHIFT_DIV1     = 5'h00;
    localparam logic [4:0] SHIFT_DIV4     = 5'h02;
    localparam logic [4:0] SHIFT_DIV8     = 5'h03;
    localparam logic [4:0] SHIFT_DIV16    = 5'h04;
    localparam logic [4:0] SHIFT_DIV128   = 5'h07;
    localparam logic [4:0] SHIFT_DIV1024  = 5'h0A;
    localparam logic [4:0] SHIFT_DIV8192  = 5'h0D;
    localparam logic [4:0] SHIFT_DIV65536 = 5'h10;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### verilog/wtc_prescaler.sv
// Tick prescaler that divides the selected slow clock by a power of two.
`timescale 1ns/1ps
`default_nettype none

module wtc_prescaler #(
    parameter int WIDTH = 16
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       slow_edge,
    input  wire logic       run,
    input  wire logic [2:0] tick_prescale_select,
    output logic            tick
);

    // Elaboration stops here when the counter cannot reach the longest divider.
    if (WIDTH < int'(wtc_pkg::SHIFT_DIV65536)) begin
        $error("wtc_prescaler: WIDTH must hold the divide-by-65536 setting");
    end

    function automatic logic [4:0] code_to_shift(input logic [2:0] code);
        case (code)
            3'h0: code_to_shift = wtc_pkg::SHIFT_DIV1;
            3'h1: code_to_shift = wtc_pkg::SHIFT_DIV4;
            3'h2: code_to_shift = wtc_pkg::SHIFT_DIV8;
            3'h3: code_to_shift = wtc_pkg::SHIFT_DIV16;
            3'h4: code_to_shift = wtc_pkg::SHIFT_DIV128;
            3'h5: code_to_shift = wtc_pkg::SHIFT_DIV1024;
            3'h6: code_to_shift = wtc_pkg::SHIFT_DIV8192;
            default: code_to_shift = wtc_pkg::SHIFT_DIV65536;
        endcase
    endfunction

    logic [WIDTH:0] count;
    logic [WIDTH:0] limit;

    assign limit = ({{WIDTH{1'b0}}, 1'b1} << code_to_shift(tick_prescale_select)) - 1'b1;

    // A change of divider restarts from zero only when the count has reached or passed the new limit.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (!run) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (slow_edge) begin
            if (count >= limit) begin
                count <= '0;
                tick  <= 1'b1;
            end else begin
                count <= count + 1'b1;
                tick  <= 1'b0;
            end
        end else begin
            tick <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ### testbench/wtc_checker_properties.sv
// Concurrent checks on the ports of the wake-up timer top module.
`timescale 1ns/1ps
`default_nettype none

module wtc_checker #(
    parameter int COUNT_WIDTH = 16
) (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        rc_slow_osc_enable,
    input wire logic        crystal_slow_osc_enable,
    input wire logic        slow_clock_source_select,
    input wire logic        backup_ram_sleep_power,
    input wire logic        sleep_state,
    input wire logic        wake
);
    // ----------------
    // Request capture
    // ----------------
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;

    // Each answer is tied to the request it belongs to, since the halves may arrive apart.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            rd_addr <= 8'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) wr_addr <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wr_data <= s_axi_wdata[7:0];
            if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
        end
    end

    // ----------------
    // Properties
    // ----------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence cfg_wr;
        $rose(s_axi_bvalid) && s_axi_bresp == wtc_pkg::RESP_OKAY
            && wr_addr == wtc_pkg::ADDR_CONFIG_LOW;
    endsequence

    sequence rd_done;
        $rose(s_axi_rvalid);
    endsequence

    rc_osc_a: assert property (cfg_wr |-> rc_slow_osc_enable == wr_data[6])
        else $error("rc oscillator enable does not follow the config write");
    xtal_osc_a: assert property (cfg_wr |-> crystal_slow_osc_enable == wr_data[5])
        else $error("crystal oscillator enable does not follow the config write");
    clk_sel_a: assert property (cfg_wr |-> slow_clock_source_select == wr_data[4])
        else $error("clock source select does not follow the config write");
    resv_zero_a: assert property (rd_done ##0 rd_addr == wtc_pkg::ADDR_CONFIG_LOW
        |-> s_axi_rdata[7] == 1'b0 && s_axi_rdata[2:1] == 2'h0)
        else $error("reserved config bits read back nonzero");
    unmapped_read_a: assert property (rd_done ##0 rd_addr > 8'h1B
        |-> s_axi_rresp == wtc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    ram_awake_a: assert property (!sleep_state |-> backup_ram_sleep_power)
        else $error("backup ram unpowered while awake");
    wake_exit_a: assert property (wake |-> sleep_state ##1 !sleep_state)
        else $error("wake did not leave the sleep state");
    wake_pulse_a: assert property (wake |=> !wake)
        else $error("wake longer than one cycle");
endmodule

bind wtc_top wtc_checker #(.COUNT_WIDTH(COUNT_WIDTH)) wtc_checker_i (
    .mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .rc_slow_osc_enable, .crystal_slow_osc_enable, .slow_clock_source_select,
    .backup_ram_sleep_power, .sleep_state, .wake
);

`default_nettype wire

// ### testbench/wtc_top_test.sv
// Self-checking bench for the wake-up timer configuration block.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) \
    begin \
        n_compared++; \
        if ((a) !== (b)) begin \
            $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
            err_count++; \
        end \
    end

module wtc_top_test;
    logic        mclk, nrst, rc_slow_oscillator, crystal_slow_oscillator, xtal_src;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        rc_slow_osc_enable, crystal_slow_osc_enable, slow_clock_source_select;
    logic        backup_ram_sleep_power, sleep_state, wake, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    int          err_count = 0, n_compared = 0, slow_edges = 0, meas;
    int          divs[6] = '{1, 4, 8, 16, 128, 1024};

    wtc_top #(.COUNT_WIDTH(16)) wtc_top_i (
        .mclk, .nrst, .rc_slow_oscillator, .crystal_slow_oscillator,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .rc_slow_osc_enable, .crystal_slow_osc_enable,
        .slow_clock_source_select, .backup_ram_sleep_power, .sleep_state, .wake, .irq
    );

    // ----------------
    // Clocks
    // ----------------
    always #20 mclk = ~mclk;

    // Slow clock of 16 mclk periods, fast enough to keep the long dividers affordable.
    always begin
        repeat (8) @(posedge mclk);
        if (xtal_src) crystal_slow_oscillator <= ~crystal_slow_oscillator;
        else rc_slow_oscillator <= ~rc_slow_oscillator;
    end

    always @(posedge rc_slow_oscillator or posedge crystal_slow_oscillator) begin
        slow_edges++;
    end

    // ----------------
    // Tasks
    // ----------------
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
        end
        err_count++;
        results();
    endtask

    task automatic axi_read(input logic [7:0] a);
        int n;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                rd = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        err_count++;
        results();
    endtask

    task automatic wait_irq;
        int n;
        for (n = 0; n < 40000; n++) begin
            @(posedge mclk);
            if (irq === 1'b1) return;
        end
        err_count++;
        results();
    endtask

    // Slow edges between two timeouts; the fixed sync latency cancels out.
    task automatic measure(input logic [2:0] code, input logic [31:0] reload);
        int c0;
        axi_write(wtc_pkg::ADDR_CONTROL, 32'h0);
        axi_write(wtc_pkg::ADDR_CONFIG_HIGH, {29'h0, code});
        axi_write(wtc_pkg::ADDR_RELOAD, reload);
        axi_write(wtc_pkg::ADDR_IRQ_MASK, 32'h1);
        axi_write(wtc_pkg::ADDR_IRQ_STATUS, 32'h3);
        axi_write(wtc_pkg::ADDR_CONTROL, 32'h1);
        wait_irq();
        c0 = slow_edges;
        axi_write(wtc_pkg::ADDR_IRQ_STATUS, 32'h1);
        wait_irq();
        meas = slow_edges - c0;
    endtask

    // ----------------
    // Sequence
    // ----------------
    initial begin
        int i;
        {mclk, nrst, rc_slow_oscillator, crystal_slow_oscillator, xtal_src} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        `CHK({sleep_state, backup_ram_sleep_power, irq}, 3'b010)
        axi_read(wtc_pkg::ADDR_CONFIG_LOW);
        `CHK(rd, 32'h0)
        axi_write(wtc_pkg::ADDR_CONFIG_LOW, 32'hFF);
        `CHK({rc_slow_osc_enable, crystal_slow_osc_enable, slow_clock_source_select}, 3'h7)
        axi_read(wtc_pkg::ADDR_CONFIG_LOW);
        `CHK(rd, 32'h79)
        axi_write(wtc_pkg::ADDR_CONFIG_LOW, 32'h0);
        `CHK({rc_slow_osc_enable, crystal_slow_osc_enable, slow_clock_source_select}, 3'h0)
        axi_read(8'h40);
        `CHK({resp, rd}, {wtc_pkg::RESP_SLVERR, 32'h0})
        axi_write(8'h40, 32'h1);
        `CHK(resp, wtc_pkg::RESP_SLVERR)
        xtal_src = 1'b1;
        axi_write(wtc_pkg::ADDR_CONFIG_LOW, 32'h20);
        measure(3'h0, 32'h3);
        `CHK(meas, 4)
        xtal_src = 1'b0;
        axi_write(wtc_pkg::ADDR_CONFIG_LOW, 32'h50);
        for (i = 1; i < 6; i++) begin
            measure(i[2:0], (i < 5) ? 32'h3 : 32'h0);
            `CHK(meas, ((i < 5) ? 4 : 1) * divs[i])
        end
        axi_write(wtc_pkg::ADDR_CONTROL, 32'h0);
        axi_write(wtc_pkg::ADDR_CONFIG_HIGH, 32'h0);
        axi_write(wtc_pkg::ADDR_CONFIG_LOW, 32'h60);
        axi_write(wtc_pkg::ADDR_IRQ_STATUS, 32'h3);
        axi_write(wtc_pkg::ADDR_CONTROL, 32'h1);
        repeat (300) @(posedge mclk);
        `CHK(irq, 1'b0)
        axi_write(wtc_pkg::ADDR_CONFIG_LOW, 32'h50);
        axi_write(wtc_pkg::ADDR_IRQ_MASK, 32'h0);
        axi_write(wtc_pkg::ADDR_CONTROL, 32'h3);
        `CHK({sleep_state, backup_ram_sleep_power}, 2'b10)
        repeat (300) @(posedge mclk);
        `CHK({sleep_state, irq}, 2'b10)
        axi_read(wtc_pkg::ADDR_IRQ_STATUS);
        `CHK(rd[0], 1'b1)
        axi_write(wtc_pkg::ADDR_CONFIG_LOW, 32'h58);
        `CHK({sleep_state, backup_ram_sleep_power}, 2'b11)
        axi_write(wtc_pkg::ADDR_IRQ_MASK, 32'h2);
        axi_write(wtc_pkg::ADDR_IRQ_STATUS, 32'h3);
        axi_write(wtc_pkg::ADDR_CONFIG_LOW, 32'h59);
        wait_irq();
        repeat (3) @(posedge mclk);
        `CHK(sleep_state, 1'b0)
        axi_read(wtc_pkg::ADDR_IRQ_STATUS);
        `CHK(rd[1], 1'b1)
        axi_write(wtc_pkg::ADDR_CONFIG_HIGH, 32'h7);
        axi_read(wtc_pkg::ADDR_CONFIG_HIGH);
        `CHK(rd, 32'h7)
        @(posedge mclk);
        nrst <= 1'b0;
        @(posedge mclk);
        nrst <= 1'b1;
        `CHK({rc_slow_osc_enable, sleep_state, backup_ram_sleep_power, irq}, 4'b0010)
        axi_read(wtc_pkg::ADDR_CONFIG_HIGH);
        `CHK(rd, 32'h0)
        axi_read(wtc_pkg::ADDR_CONFIG_LOW);
        `CHK(rd, 32'h0)
        results();
    end
endmodule

`default_nettype wire
